// ---- hdl/dcm_clock_gen.sv ----
`timescale 1ns/100ps
// Functional notes
// - Output clock is reference scaled by selected ratio
// - Loop bypassed: divide reference by two or four
// - Loop on: multiply by N in quarter steps
// - Multiplier change: up to 30 us unlocked
// - In bypass a slow or stopped reference keeps state; multiply mode keeps running at the last period
module dcm_clock_gen
	import dcm_pkg::*;
#(
	parameter int PW = PERIOD_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reference_clock_input,
	input wire dcm_ratio_type clock_ratio_select_register,
	output logic crystal_drive_pin,
	output logic machine_clock_output,
	output logic machine_clock_rise,
	output logic pll_locked
);

	// Reference edge and period from the meter
	logic ref_rise;
	logic [PW-1:0] ref_period;
	logic period_valid;

	// All state of the generator
	typedef struct packed {
		dcm_state_type state; // Ratio change sequencing
		dcm_ratio_type active; // Ratio now driving the clock
		dcm_ratio_type pending; // Ratio waiting to take over
		logic [LOCK_W-1:0] lock_cnt; // Cycles left in unlocked phase
		logic [PW+1:0] acc; // Multiply mode phase accumulator
		logic div_cnt; // Divide by four half step
		logic clk_out; // Machine clock level
		logic rise; // Machine clock rose this cycle
		logic locked; // Multiply mode is stable
		logic xtal; // Inverted reference for the crystal
	} dcm_gen_type;

	dcm_gen_type s;
	dcm_gen_type next_s;

	// Multiplier in quarter steps, forced to at least one
	logic [MULT_W-1:0] mult_q;
	// Accumulator after this cycle's step
	logic [PW+1:0] acc_sum;
	// Accumulator left after a level change
	logic [PW+1:0] acc_rem;
	// Half reference period scaled by four: twice the period
	logic [PW+1:0] half_scaled;
	// Output clock should change level this cycle
	logic toggle;

	// Reference edge detection and period measurement
	dcm_ref_meter #(
		.PW(PW)
	) u_meter (
		.clk_sys(clk_sys),
		.rst(rst),
		.reference_clock_input(reference_clock_input),
		.ref_rise(ref_rise),
		.ref_period(ref_period),
		.period_valid(period_valid)
	);

	// Multiplier clamp and accumulator arithmetic
	always_comb begin
		// Values below one count as one
		if (s.active.mult_quarters < MULT_MIN_Q) begin
			mult_q = MULT_MIN_Q;
		end else begin
			mult_q = s.active.mult_quarters;
		end
		// One step of N quarters per system cycle
		acc_sum = s.acc + {{(PW-4){1'b0}}, mult_q};
		half_scaled = {1'b0, ref_period, 1'b0};
		acc_rem = acc_sum - half_scaled;
	end

	// Decide whether the machine clock changes level
	always_comb begin
		// Default: hold the level, as a stopped reference needs
		toggle = 1'b0;
		if (!s.active.pll_enable) begin
			// Bypass: follow reference edges only
			if (ref_rise) begin
				if (s.active.div_by_four) begin
					// Every second edge: four reference periods
					toggle = s.div_cnt;
				end else begin
					// Every edge: two reference periods
					toggle = 1'b1;
				end
			end
		end else if (period_valid) begin
			// Multiply: N output periods per reference period
			toggle = (acc_sum >= half_scaled);
		end else begin
			// No period measured yet: level holds
			toggle = 1'b0;
		end
	end

	// Next state of the generator
	always_comb begin
		// Pulses and crystal drive are rebuilt each cycle
		next_s = s;
		next_s.rise = 1'b0;
		next_s.xtal = ~reference_clock_input;

		// Divide by four counts reference edges
		if (!s.active.pll_enable && ref_rise) begin
			// Cleared at each switch so a new ratio starts clean
			next_s.div_cnt = ~s.div_cnt;
		end

		// Accumulator only runs on a measured period
		if (s.active.pll_enable && period_valid) begin
			if (toggle && acc_rem >= half_scaled) begin
				// Faster than half the system rate: cap, no runaway
				next_s.acc = half_scaled;
			end else if (toggle) begin
				// Keep the remainder so fractional N averages out
				next_s.acc = acc_rem;
			end else begin
				// Still climbing towards the half period
				next_s.acc = acc_sum;
			end
		end

		// Output level; in bypass a stopped reference simply holds it
		if (toggle) begin
			// A change from low raises the one-cycle pulse
			next_s.clk_out = ~s.clk_out;
			next_s.rise = ~s.clk_out;
		end

		// Sequencing of ratio changes
		case (s.state)
			DCM_RUN: begin
				// New selection seen: old clock keeps running
				if (clock_ratio_select_register != s.active) begin
					next_s.pending = clock_ratio_select_register;
					if (clock_ratio_select_register.pll_enable) begin
						// Loop needs its unlocked phase
						next_s.lock_cnt = LOCK_W'(LOCK_CYCLES - 1);
						next_s.state = DCM_LOCK;
					end else begin
						// Bypass target: no lock wait
						next_s.state = DCM_SWITCH;
					end
				end else begin
					// Selection matches: keep running
					next_s.state = DCM_RUN;
				end
			end
			DCM_LOCK: begin
				if (clock_ratio_select_register != s.pending) begin
					// Selection moved again: start over
					next_s.state = DCM_RUN;
				end else if (s.lock_cnt == '0) begin
					next_s.state = DCM_SWITCH;
				end else begin
					// Old clock keeps driving meanwhile
					next_s.lock_cnt = s.lock_cnt - LOCK_W'(1);
				end
			end
			DCM_SWITCH: begin
				if (clock_ratio_select_register != s.pending) begin
					// Selection moved again: start over
					next_s.state = DCM_RUN;
				end else if (!s.clk_out) begin
					// Switch only in the low phase, holding it low
					next_s.active = s.pending;
					next_s.acc = '0;
					next_s.div_cnt = 1'b0;
					next_s.clk_out = 1'b0;
					next_s.rise = 1'b0;
					next_s.locked = s.pending.pll_enable;
					next_s.state = DCM_RUN;
				end else begin
					// High phase: wait, never cut it short
					next_s.state = DCM_SWITCH;
				end
			end
			default: begin
				// Unused code: back to normal running
				next_s.state = DCM_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		// Reset: bypass divide by two, clock low
		if (rst) begin
			s.state <= DCM_RUN;
			s.active <= RATIO_RESET;
			s.pending <= RATIO_RESET;
			s.lock_cnt <= '0;
			s.acc <= '0;
			s.div_cnt <= 1'b0;
			s.clk_out <= 1'b0;
			s.rise <= 1'b0;
			s.locked <= 1'b0;
			s.xtal <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state
	assign crystal_drive_pin = s.xtal;
	assign machine_clock_output = s.clk_out;
	assign machine_clock_rise = s.rise;
	// Locked only while the multiplied clock drives
	assign pll_locked = s.locked & s.active.pll_enable;

endmodule

// ---- hdl/dcm_ref_meter.sv ----
`timescale 1ns/100ps
// Finds reference edges and measures the reference period
module dcm_ref_meter
	import dcm_pkg::*;
#(
	parameter int PW = PERIOD_W
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reference_clock_input,
	output logic ref_rise,
	output logic [PW-1:0] ref_period,
	output logic period_valid
);

	// All state of the meter
	typedef struct packed {
		logic ref_prev; // Reference level one cycle ago
		logic seen_edge; // A first rising edge has passed
		logic [PW-1:0] count; // Cycles since the last rising edge
		logic [PW-1:0] period; // Last complete period
		logic valid; // Period holds a measurement
		logic rise; // Rising edge found this cycle
	} dcm_meter_type;

	dcm_meter_type s;
	dcm_meter_type next_s;

	// Edge detection and period counting
	always_comb begin
		next_s = s;
		next_s.ref_prev = reference_clock_input;
		next_s.rise = reference_clock_input & ~s.ref_prev;
		if (next_s.rise) begin
			// Period ends on each rising edge after the first
			if (s.seen_edge) begin
				next_s.period = s.count;
				next_s.valid = 1'b1;
			end
			next_s.seen_edge = 1'b1;
			next_s.count = {{(PW-1){1'b0}}, 1'b1};
		end else if (s.count != {PW{1'b1}}) begin
			// Saturate so a stopped reference keeps its last period
			next_s.count = s.count + {{(PW-1){1'b0}}, 1'b1};
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// Track the pin level so release brings no false edge
			s <= '{ref_prev: reference_clock_input, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign ref_rise = s.rise;
	assign ref_period = s.period;
	assign period_valid = s.valid;

endmodule

// ---- shared/dcm_pkg.sv ----
// Shared constants and types for the machine clock generator
package dcm_pkg;

	// System clock period in picoseconds (125 MHz)
	localparam int CLK_PERIOD_PS = 8000;

	// Longest unlocked phase after a multiplier change, in ns
	localparam int LOCK_TIME_NS = 30000;
	// Least time rounds up to whole system cycles
	localparam int LOCK_CYCLES =
		(LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Width of the lock wait counter
	localparam int LOCK_W = 12;

	// Default width of the reference period counter
	localparam int PERIOD_W = 16;

	// Width of the multiplier field, in quarter steps
	localparam int MULT_W = 6;
	// Smallest legal multiplier: one, in quarter steps
	localparam logic [5:0] MULT_MIN_Q = 6'h04;

	// Ratio selection as held by the clock ratio select register
	typedef struct packed {
		logic pll_enable; // Multiply mode when set
		logic div_by_four; // Divide by four, else by two
		logic [5:0] mult_quarters; // Multiplier N times four
	} dcm_ratio_type;

	// Ratio after reset: loop bypassed, divide by two
	localparam dcm_ratio_type RATIO_RESET = '{
		pll_enable: 1'b0,
		div_by_four: 1'b0,
		mult_quarters: 6'h04
	};

	// Generator states, Gray coded along run, lock, switch
	typedef enum logic [1:0] {
		DCM_RUN = 2'h0,
		DCM_LOCK = 2'h1,
		DCM_SWITCH = 2'h3
	} dcm_state_type;

endpackage

// ---- tb/dcm_clock_gen_properties.sv ----
`timescale 1ns/100ps
// Port checks of the clock generator
module dcm_clock_gen_properties
	import dcm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reference_clock_input,
	input wire dcm_ratio_type clock_ratio_select_register,
	input wire logic crystal_drive_pin,
	input wire logic machine_clock_output,
	input wire logic machine_clock_rise,
	input wire logic pll_locked
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire logic ri = reference_clock_input;
	wire logic mo = machine_clock_output;
	wire logic rs = machine_clock_rise;
	wire dcm_ratio_type s = clock_ratio_select_register;
	dcm_ratio_type sq; // Previous selection
	logic [11:0] wc; // Cycles since selection change
	logic [1:0] rr; // Reference rises since toggle
	logic [7:0] mr; // Output rises, in quarters
	// Settled bypass mode
	wire logic dv = wc >= 12'h0c8 && !s.pll_enable && !pll_locked;
	// Helper counters
	always_ff @(posedge clk_sys) begin
		sq <= s;
		if (rst || sq != s) wc <= 12'h000;
		else if (wc != 12'hfff) wc <= wc + 12'h001;
		if (rst || $changed(mo)) rr <= 2'h0;
		else if ($rose(ri) && rr != 2'h3) rr <= rr + 2'h1;
		if (rst || $rose(ri)) mr <= 8'h00;
		else if (rs && mr < 8'hf0) mr <= mr + 8'h04;
	end
	a_rise_pulse: assert property (rs |-> mo && !$past(mo))
		else $error("stray rise pulse");
	a_xtal_inverse: assert property
		(!$past(rst) |-> crystal_drive_pin == !$past(ri))
		else $error("crystal drive wrong");
	a_div_delay: assert property
		(dv && !s.div_by_four && $rose(ri) |-> ##[2:3] $changed(mo))
		else $error("divided clock late");
	a_div_ratio: assert property
		(dv && $changed(mo) |-> rr == (s.div_by_four ? 2'h2 : 2'h1))
		else $error("divide ratio wrong");
	a_stop_hold: assert property
		(dv && !ri && !$past(ri) && !$past(ri, 2) && !$past(ri, 3)
		|-> $stable(mo))
		else $error("clock moved");
	a_lock_wait: assert property
		($rose(pll_locked) |-> s.pll_enable && wc >= LOCK_CYCLES - 1)
		else $error("lock too early");
	a_lock_due: assert property
		(s.pll_enable && wc == LOCK_CYCLES + 200 |-> pll_locked)
		else $error("lock too late");
	a_mult_rate: assert property
		($rose(ri) && s.pll_enable && wc >= LOCK_CYCLES + 250
		|-> mr + 8'h04 >= s.mult_quarters && mr <= s.mult_quarters + 8'h04)
		else $error("multiplied rate wrong");
endmodule

// ---- tb/dcm_ref_src.sv ----
`timescale 1ns/100ps
// Reference source; a stopped clock holds its level
module dcm_ref_src (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic [7:0] half,
	output logic ref_clk
);
	int n = 0; // Cycles in this phase
	initial ref_clk = 1'b0;
	// Toggle every half period
	always @(negedge clk_sys) begin
		if (run) begin
			n = n + 1;
			if (n >= half) begin
				n = 0;
				ref_clk = ~ref_clk;
			end
		end
	end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
// Bench for the clock generator
module tb_top
	import dcm_pkg::*;
;
	logic clk_sys = 1'b0, rst = 1'b1, run = 1'b1, refc, xp, mco, mcr, lk;
	logic [7:0] half = 8'h05; // Reference half period
	int num_errors = 0, comparisons = 0;
	dcm_ratio_type sel = RATIO_RESET;
	dcm_clock_gen dut (.clk_sys(clk_sys), .rst(rst),
		.reference_clock_input(refc), .clock_ratio_select_register(sel),
		.crystal_drive_pin(xp), .machine_clock_output(mco),
		.machine_clock_rise(mcr), .pll_locked(lk));
	dcm_ref_src src (.clk_sys(clk_sys), .run(run), .half(half),
		.ref_clk(refc));
	task automatic check(string nm, int lo, int hi, int got);
		comparisons++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("wrong value %s expected %0d..%0d seen %0d",
				nm, lo, hi, got);
		end
	endtask
	task automatic check_bit(string nm, logic e, logic g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask
	// Count output rises over c cycles
	task automatic rises(int c, output int n);
		n = 0;
		repeat (c) begin
			@(negedge clk_sys);
			if (mcr !== 1'b0) n++;
		end
	endtask
	task automatic final_report;
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Bypass divide by two or four
	task automatic t_div(logic d4);
		int n;
		sel = '{1'b0, d4, 6'h04};
		repeat (300) @(negedge clk_sys);
		rises(400, n);
		check("div rises", d4 ? 10 : 20, d4 ? 10 : 20, n);
	endtask
	// Stopped reference, then resume
	task automatic t_stop;
		int n;
		run = 1'b0;
		rises(500, n);
		check("stopped rises", 0, 0, n);
		check_bit("crystal drive", ~refc, xp);
		run = 1'b1;
		t_div(1'b0);
	endtask
	// Multiply mode, optionally aborting a first lock
	task automatic t_mult(logic [5:0] q, logic [7:0] h, logic ab);
		int n;
		sel = RATIO_RESET;
		half = h;
		repeat (200) @(negedge clk_sys);
		if (ab) begin
			sel = '{1'b1, 1'b0, q + 6'h04};
			repeat (1000) @(negedge clk_sys);
			check_bit("early lock", 1'b0, lk);
		end
		sel = '{1'b1, 1'b0, q};
		n = 0;
		while (lk !== 1'b1 && n < LOCK_CYCLES + 300) begin
			@(negedge clk_sys);
			n++;
		end
		check("lock wait", LOCK_CYCLES - 1, LOCK_CYCLES + 200, n);
		rises(80 * h, n);
		check("mult rises", 10 * q - 2, 10 * q + 2, n);
	endtask
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		t_div(1'b0);
		t_div(1'b1);
		t_stop;
		t_mult(6'h08, 8'h08, 1'b1);
		t_mult(6'h0a, 8'h06, 1'b0);
		t_mult(6'h09, 8'h03, 1'b0);
		t_mult(6'h04, 8'h0a, 1'b0);
		final_report;
	end
	// Watchdog
	initial begin
		#600000;
		num_errors++;
		final_report;
	end
endmodule
bind dcm_clock_gen dcm_clock_gen_properties chk (.clk_sys(clk_sys),
	.rst(rst), .reference_clock_input(reference_clock_input),
	.clock_ratio_select_register(clock_ratio_select_register),
	.crystal_drive_pin(crystal_drive_pin),
	.machine_clock_output(machine_clock_output),
	.machine_clock_rise(machine_clock_rise), .pll_locked(pll_locked));
